// ---- dcc_ctrl.sv ----
// Disconnector command control: checks, timed pulses, position supervision
module dcc_ctrl
  import dcc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire dcc_req_t         local_req,
  input  wire dcc_req_t         remote_req,
  input  wire logic             local_permission_in,
  input  wire logic             remote_permission_in,
  input  wire logic             open_interlock_enable,
  input  wire logic             close_interlock_enable,
  input  wire logic             operation_block,
  input  wire logic             position_open_in,
  input  wire logic             position_closed_in,
  input  wire dcc_model_t       control_model,
  input  wire logic             forced_check,
  input  wire dcc_cfg_t         cfg,
  input  wire logic             counter_clear,
  output logic                  open_pulse_out,
  output logic                  close_pulse_out,
  output logic                  oper_pulse_out,
  output logic [1:0]            position_status,
  output logic                  opened_out,
  output logic                  closed_out,
  output logic                  cmd_refused,
  output logic                  invalid_position,
  output logic [CNT_W-1:0]      oper_count
);

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic [31:0] div_reg, div_next;
  logic        tick_reg, tick_next;

  always_comb begin
    tick_next = 1'b0;
    div_next  = div_reg + 32'h1;
    if (div_reg >= 32'(TICK_DIV - 1)) begin
      div_next  = 32'h0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      div_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ---------------------------------------------------------------
  // Position processing
  // ---------------------------------------------------------------
  logic [1:0]    raw_pos;
  logic [1:0]    pos_reg, pos_next;
  logic [TW-1:0] inter_ms_reg, inter_ms_next;
  logic          opened_reg, opened_next;
  logic          closed_reg, closed_next;
  logic          oper_reg, oper_next;
  logic [TW-1:0] oper_ms_reg, oper_ms_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0]    last_reg, last_next;

  assign raw_pos = {position_closed_in, position_open_in};

  always_comb begin
    pos_next      = pos_reg;
    inter_ms_next = inter_ms_reg;
    opened_next   = opened_reg;
    closed_next   = closed_reg;
    oper_next     = oper_reg;
    oper_ms_next  = oper_ms_reg;
    cnt_next      = cnt_reg;
    last_next     = last_reg;
    if (raw_pos == POS_INTER) begin
      // Travel is hidden until the intermediate wait expires
      if (tick_reg && inter_ms_reg != {TW{1'b1}})
        inter_ms_next = inter_ms_reg + 1'b1;
      if (inter_ms_reg >= cfg.max_inter_ms)
        pos_next = POS_INTER;
    end else begin
      inter_ms_next = '0;
      pos_next      = raw_pos;
    end
    opened_next = (pos_next == POS_OPEN);
    closed_next = (pos_next == POS_CLOSED);
    if (oper_reg && tick_reg) begin
      oper_ms_next = oper_ms_reg + 1'b1;
      if (oper_ms_reg >= TW'(OPER_PULSE_MS - 1))
        oper_next = 1'b0;
    end
    // Compare with last settled end, so a reported travel still counts
    if ((pos_next == POS_OPEN || pos_next == POS_CLOSED) &&
        (last_reg == POS_OPEN || last_reg == POS_CLOSED) &&
        pos_next != last_reg) begin
      oper_next    = 1'b1;
      oper_ms_next = '0;
    end
    if (pos_next == POS_OPEN || pos_next == POS_CLOSED)
      last_next = pos_next;
    if (oper_next && !oper_reg)
      cnt_next = cnt_reg + 1'b1;
    else if (counter_clear)
      cnt_next = '0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pos_reg      <= POS_INTER;
      inter_ms_reg <= '0;
      opened_reg   <= 1'b0;
      closed_reg   <= 1'b0;
      oper_reg     <= 1'b0;
      oper_ms_reg  <= '0;
      cnt_reg      <= '0;
      last_reg     <= POS_INTER;
    end else begin
      pos_reg      <= pos_next;
      inter_ms_reg <= inter_ms_next;
      opened_reg   <= opened_next;
      closed_reg   <= closed_next;
      oper_reg     <= oper_next;
      oper_ms_reg  <= oper_ms_next;
      cnt_reg      <= cnt_next;
      last_reg     <= last_next;
    end
  end

  // ---------------------------------------------------------------
  // Command acceptance and sequencing
  // ---------------------------------------------------------------
  dcc_state_t    st_reg, st_next;
  logic          dir_reg, dir_next;
  logic [TW-1:0] ms_reg, ms_next;
  logic          open_reg, open_next;
  logic          close_reg, close_next;
  logic          refuse_reg, refuse_next;
  logic          inval_reg, inval_next;

  dcc_req_t req;
  logic     src_ok, dir_ok, chk_ok, done, enh;

  always_comb begin
    // Local wins when both sources strobe together
    req = '0;
    src_ok = 1'b0;
    if (local_req.select || local_req.operate) begin
      req    = local_req;
      src_ok = local_permission_in;
    end else if (remote_req.select || remote_req.operate) begin
      req    = remote_req;
      src_ok = remote_permission_in;
    end
    dir_ok = req.close_dir ? close_interlock_enable
                           : open_interlock_enable;
    // Skip honoured only when forced check is off; block always applies
    chk_ok = src_ok && !operation_block &&
             (dir_ok || (req.skip_check && !forced_check));
    done = dir_reg ? (raw_pos == POS_CLOSED) : (raw_pos == POS_OPEN);
    enh  = (control_model != DCC_DIRECT_NORMAL);
  end

  always_comb begin
    st_next     = st_reg;
    dir_next    = dir_reg;
    ms_next     = ms_reg;
    open_next   = 1'b0;
    close_next  = 1'b0;
    refuse_next = 1'b0;
    inval_next  = 1'b0;
    if (tick_reg && ms_reg != {TW{1'b1}})
      ms_next = ms_reg + 1'b1;
    unique case (st_reg)
      DCC_IDLE: begin
        if (req.select && control_model == DCC_SBO_ENHANCED) begin
          if (chk_ok) begin
            st_next  = DCC_SELECTED;
            dir_next = req.close_dir;
            ms_next  = '0;
          end else
            refuse_next = 1'b1;
        end else if (req.operate) begin
          // Operate without selection is refused in SBO
          if (chk_ok && control_model != DCC_SBO_ENHANCED) begin
            st_next  = DCC_PULSE;
            dir_next = req.close_dir;
            ms_next  = '0;
          end else
            refuse_next = 1'b1;
        end
      end
      DCC_SELECTED: begin
        if (ms_reg >= cfg.sbo_ms)
          st_next = DCC_IDLE;
        else if (req.operate) begin
          if (chk_ok && req.close_dir == dir_reg) begin
            st_next = DCC_PULSE;
            ms_next = '0;
          end else begin
            st_next     = DCC_IDLE;
            refuse_next = 1'b1;
          end
        end
      end
      DCC_PULSE: begin
        // Confirmed switching ends the pulse, not before the minimum
        if (ms_reg >= cfg.pulse_ms ||
            (done && ms_reg >= TW'(MIN_PULSE_MS))) begin
          st_next = DCC_WAIT;
        end else begin
          open_next  = !dir_reg;
          close_next = dir_reg;
        end
      end
      DCC_WAIT: begin
        if (done || !enh)
          st_next = DCC_IDLE;
        else if (ms_reg >= cfg.max_oper_ms) begin
          st_next    = DCC_IDLE;
          inval_next = 1'b1;
        end
      end
      default: st_next = DCC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg     <= DCC_IDLE;
      dir_reg    <= 1'b0;
      ms_reg     <= '0;
      open_reg   <= 1'b0;
      close_reg  <= 1'b0;
      refuse_reg <= 1'b0;
      inval_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      dir_reg    <= dir_next;
      ms_reg     <= ms_next;
      open_reg   <= open_next;
      close_reg  <= close_next;
      refuse_reg <= refuse_next;
      inval_reg  <= inval_next;
    end
  end

  assign open_pulse_out   = open_reg;
  assign close_pulse_out  = close_reg;
  assign oper_pulse_out   = oper_reg;
  assign position_status  = pos_reg;
  assign opened_out       = opened_reg;
  assign closed_out       = closed_reg;
  assign cmd_refused      = refuse_reg;
  assign invalid_position = inval_reg;
  assign oper_count       = cnt_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence local_try_s;
    local_req.operate && !local_permission_in;
  endsequence

  no_both_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(open_pulse_out && close_pulse_out)) else $error("both pulses");

  local_perm_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (local_try_s and st_reg == DCC_IDLE) |=> cmd_refused)
    else $error("local without permission");

  remote_perm_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_reg == DCC_IDLE && remote_req.operate && !local_req.operate &&
     !local_req.select && !remote_permission_in) |=> cmd_refused)
    else $error("remote without permission");

  block_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_reg == DCC_IDLE && req.operate && operation_block) |=> cmd_refused)
    else $error("blocked command not refused");

  pulse_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(open_pulse_out) |-> $past(st_reg) == DCC_PULSE && !dir_reg)
    else $error("open pulse without open command");

  min_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(close_pulse_out) |-> ms_reg >= cfg.pulse_ms ||
      ms_reg >= TW'(MIN_PULSE_MS))
    else $error("close pulse too short");

  pos_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    raw_pos != POS_INTER |=> position_status == $past(raw_pos))
    else $error("position code wrong");

  oper_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(oper_pulse_out) |-> oper_count == $past(oper_count) + 1'b1)
    else $error("counter missed operation");

  sbo_timeout_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_reg == DCC_SELECTED && ms_reg >= cfg.sbo_ms) |=> st_reg == DCC_IDLE)
    else $error("selection outlived timeout");

endmodule : dcc_ctrl

// ---- dcc_gear.sv ----
// Behavioural disconnector gear that answers the command pulses
module dcc_gear #(
  parameter int TICK = 10
) (
  input  wire logic        sys_clk,
  input  wire logic        open_pulse_out,
  input  wire logic        close_pulse_out,
  input  wire logic [1:0]  gear_mode,
  input  wire logic [15:0] travel_ms,
  output logic             position_open_in,
  output logic             position_closed_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Travel model
  // ----------------------------------------------------------
  // Mode 0 travels, 1 is jammed, 2 shorts both contacts
  logic closed_reg = 1'b1;
  logic moving_reg = 1'b0;
  int   cnt_reg    = 0;
  always @(posedge sys_clk) begin
    if (gear_mode == 2'h1) begin
      cnt_reg <= 0;
    end else if (!moving_reg) begin
      if (closed_reg ? open_pulse_out : close_pulse_out) begin
        moving_reg <= 1'b1;
        cnt_reg    <= travel_ms * TICK;
      end
    end else if (cnt_reg > 0) begin
      cnt_reg <= cnt_reg - 1;
    end else begin
      moving_reg <= 1'b0;
      closed_reg <= !closed_reg;
    end
  end
  // Both contacts drop while the blades travel
  assign position_open_in   = gear_mode == 2'h2 ||
                              (!moving_reg && !closed_reg);
  assign position_closed_in = gear_mode == 2'h2 ||
                              (!moving_reg && closed_reg);
endmodule : dcc_gear

// ---- dcc_pkg.sv ----
// Constants and carrier types for the disconnector command control block
// Overview of operation
// - Local panel commands accepted only while local permission is asserted.
// - Remote or web commands accepted only while remote permission is asserted.
// - Local and remote paths are permitted independently by their own inputs.
// - Open commands execute only while open interlock enable is asserted; the code also executes them when skip_check is set and forced_check is off.
// - Close commands execute only while close interlock enable is asserted; the code also executes them when skip_check is set and forced_check is off.
// - Operation block input refuses switching in either direction.
// - Accepted commands are checked, driven out, and position status reported.
// - Control model is direct normal, direct enhanced or SBO; default direct normal.
// - Forced check on by default performs checks despite skip attribute.
// - Enhanced models flag invalid position if no change within max operating time.
// - Command pulses last configured duration, 100 to 60000 ms, default 1000.
// - Pulse ends early on confirmed switching, but never before 1000 ms.
// - Wait intermediate time for valid position, then report intermediate.
// - SBO operate must follow selection within timeout or nothing is done.
// - Processed position status is offered to display and supervisory system.
// - Position code: 0 intermediate, 1 open, 2 closed, 3 bad.
// - A 150 ms operation pulse is emitted each time the disconnector operates.
// - Operation counter increments per operation pulse; reset request clears it.
// - Command needs matching permission and direction enable at the same moment.
package dcc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 250;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES     = TICK_NS * CLK_MHZ / 1000;
  localparam int TW              = 16;
  localparam int MIN_PULSE_MS    = 1000;
  localparam int OPER_PULSE_MS   = 150;
  localparam int DEF_MAX_OPER_MS = 10000;
  localparam int DEF_PULSE_MS    = 1000;
  localparam int DEF_MAX_INTER_MS = 10000;
  localparam int DEF_SBO_MS      = 5000;
  localparam int CNT_W           = 32;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DCC_DIRECT_NORMAL   = 2'h0,
    DCC_DIRECT_ENHANCED = 2'h1,
    DCC_SBO_ENHANCED    = 2'h2
  } dcc_model_t;

  localparam logic [1:0] POS_INTER  = 2'h0;
  localparam logic [1:0] POS_OPEN   = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_BAD    = 2'h3;

  typedef enum logic [3:0] {
    DCC_IDLE     = 4'h1,
    DCC_SELECTED = 4'h2,
    DCC_PULSE    = 4'h4,
    DCC_WAIT     = 4'h8
  } dcc_state_t;

  // Command request from one source
  typedef struct packed {
    logic select;     // SBO selection strobe
    logic operate;    // Operate strobe
    logic close_dir;  // 1 close, 0 open
    logic skip_check; // Check attribute asks to skip checks
  } dcc_req_t;

  // Timing settings in ms
  typedef struct packed {
    logic [TW-1:0] max_oper_ms;
    logic [TW-1:0] pulse_ms;
    logic [TW-1:0] max_inter_ms;
    logic [TW-1:0] sbo_ms;
  } dcc_cfg_t;

endpackage : dcc_pkg

// ---- dcc_tb.sv ----
// Self-checking bench for the disconnector command control block
module tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------
  localparam int TK = 10;
  localparam logic [7:0] TBL [6] = '{8'h0E, 8'h96, 8'h1A, 8'hDC,
                                     8'h1F, 8'h3A};
  logic             sys_clk = 1'b0;
  logic             rst_b   = 1'b0;
  dcc_req_t         lr      = '0;
  dcc_req_t         rr      = '0;
  logic             lp = 1'b1, rp = 1'b1, oe = 1'b1, ce = 1'b1;
  logic             blk = 1'b0, fc = 1'b1, clr = 1'b0;
  dcc_model_t       model   = DCC_DIRECT_NORMAL;
  dcc_cfg_t         cfg     = '{16'h0190, 16'h04B0, 16'h0032, 16'h03E8};
  logic [1:0]       gmode   = 2'h0;
  logic [15:0]      travel  = 16'h00C8;
  logic             pos_open, pos_closed, open_pulse_out, close_pulse_out;
  logic             oper_pulse_out, opened_out, closed_out, cmd_refused;
  logic             invalid_position, inv_seen;
  logic [1:0]       position_status;
  logic [CNT_W-1:0] oper_count;
  int               plen, olen, n_mismatch, cmp_count;

  always #2 sys_clk = ~sys_clk;

  dcc_ctrl #(.TICK_DIV(TK)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .local_req(lr), .remote_req(rr),
    .local_permission_in(lp), .remote_permission_in(rp),
    .open_interlock_enable(oe), .close_interlock_enable(ce),
    .operation_block(blk), .position_open_in(pos_open),
    .position_closed_in(pos_closed), .control_model(model),
    .forced_check(fc), .cfg(cfg), .counter_clear(clr),
    .open_pulse_out(open_pulse_out), .close_pulse_out(close_pulse_out),
    .oper_pulse_out(oper_pulse_out), .position_status(position_status),
    .opened_out(opened_out), .closed_out(closed_out),
    .cmd_refused(cmd_refused), .invalid_position(invalid_position),
    .oper_count(oper_count));

  dcc_gear #(.TICK(TK)) gear_u (
    .sys_clk(sys_clk), .open_pulse_out(open_pulse_out),
    .close_pulse_out(close_pulse_out), .gear_mode(gmode),
    .travel_ms(travel), .position_open_in(pos_open),
    .position_closed_in(pos_closed));

  always @(posedge sys_clk) begin
    if (open_pulse_out === 1'b1 || close_pulse_out === 1'b1) plen++;
    if (oper_pulse_out === 1'b1) olen++;
    if (invalid_position === 1'b1) inv_seen = 1'b1;
  end

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic ms(input int n);
    repeat (n * TK) @(negedge sys_clk);
  endtask : ms

  task automatic wait_low(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (open_pulse_out === 1'b0 && close_pulse_out === 1'b0) break;
      @(negedge sys_clk);
    end
    if (i == lim) begin
      chk(1'b0, "command pulse never ended");
      close_out();
    end
  endtask : wait_low

  // Strobe one request, then watch three cycles for its outcome
  task automatic issue(input bit rem, cls, sel, skip, er, ep);
    dcc_req_t r;
    bit       rs, ps;
    r  = '{sel, !sel, cls, skip};
    rs = 1'b0;
    ps = 1'b0;
    @(negedge sys_clk);
    plen     = 0;
    olen     = 0;
    inv_seen = 1'b0;
    if (rem) rr = r;
    else lr = r;
    @(negedge sys_clk);
    lr = '0;
    rr = '0;
    repeat (3) begin
      rs |= cmd_refused === 1'b1;
      ps |= open_pulse_out === 1'b1 || close_pulse_out === 1'b1;
      @(negedge sys_clk);
    end
    chk(rs == er && ps == ep, "unexpected command outcome");
  endtask : issue

  initial begin
    logic [7:0] t;
    repeat (2) @(negedge sys_clk);
    chk(open_pulse_out === 1'b0 && close_pulse_out === 1'b0, "rst");
    rst_b = 1'b1;
    ms(60);
    chk(position_status === POS_CLOSED && closed_out === 1'b1, "st");
    for (int i = 0; i < 6; i++) begin
      t = TBL[i];
      {lp, rp, oe, ce, blk} = t[4:0];
      issue(t[7], t[6], 1'b0, t[5], 1'b1, 1'b0);
    end
    $display("refusal test ended");
    {lp, rp, oe, ce, blk} = 5'h16;
    chk(oper_count === 32'h0, "counter not zero");
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(open_pulse_out === 1'b1 && close_pulse_out === 1'b0, "dir");
    ms(40);
    chk(position_status === POS_CLOSED, "prior code not held");
    ms(60);
    chk(position_status === POS_INTER, "no intermediate code");
    ms(110);
    chk(position_status === POS_OPEN && opened_out === 1'b1, "op");
    wait_low(20000);
    chk(plen >= 9990 && plen <= 10020, "early end too soon");
    ms(20);
    chk(olen >= 1490 && olen <= 1520, "operation pulse width");
    chk(oper_count === 32'h1, "counter not advanced");
    $display("open test ended");
    model = DCC_DIRECT_ENHANCED;
    {fc, ce, gmode, cfg.pulse_ms} = {1'b0, 1'b0, 2'h1, 16'h012C};
    issue(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk(close_pulse_out === 1'b1, "close pulse missing");
    wait_low(4000);
    chk(plen >= 2990 && plen <= 3010, "pulse duration");
    ms(90);
    chk(inv_seen === 1'b0, "invalid position too early");
    ms(20);
    chk(inv_seen === 1'b1, "invalid position missing");
    $display("jammed test ended");
    {gmode, fc, ce, rp, travel} = {2'h0, 3'h7, 16'h0032};
    model = DCC_SBO_ENHANCED;
    issue(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    issue(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    ms(1100);
    issue(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    issue(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    ms(500);
    issue(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_low(12000);
    ms(200);
    chk(position_status === POS_CLOSED, "not closed");
    chk(oper_count === 32'h2, "second operation not counted");
    $display("select test ended");
    gmode = 2'h2;
    ms(60);
    chk(position_status === POS_BAD, "bad code missing");
    $display("contact test ended");
    clr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    @(negedge sys_clk);
    chk(oper_count === 32'h0, "counter not cleared");
    $display("clear test ended");
    close_out();
  end
endmodule : tb
